// File: ihc_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module ihc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	output logic [WIDTH-1:0] out_data_out,
	output logic out_valid_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0] wr_ptr_ff;
	logic [AW:0] rd_ptr_ff;
	logic full;
	logic empty;
	logic do_wr;
	logic do_rd;

	// The extra pointer bit tells a full ring from an empty one.
	assign empty = (wr_ptr_ff == rd_ptr_ff);
	assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
	assign in_ready_out = ~full;
	assign out_valid_out = ~empty;
	assign out_data_out = mem_ff[rd_ptr_ff[AW-1:0]];
	assign do_wr = in_valid_in & ~full;
	assign do_rd = out_ready_in & ~empty;

	always_ff @(posedge clk_in) begin
		if (do_wr) begin
			mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			wr_ptr_ff <= '0;
		end else if (do_wr) begin
			wr_ptr_ff <= wr_ptr_ff + 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rd_ptr_ff <= '0;
		end else if (do_rd) begin
			rd_ptr_ff <= rd_ptr_ff + 1'b1;
		end
	end

endmodule
`default_nettype wire

// File: ihc_host_model.sv
// Bus-master model that clocks bytes in and out of the host port.
`timescale 1ns/100ps
`default_nettype none
module ihc_host_model (
	input wire logic lclk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_low_out
);
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	// Four link clocks per half period keep the bus slow enough to oversample.
	task automatic half();
		repeat (4) @(posedge lclk_in);
	endtask
	task automatic start();
		sda_low_out = 1'b1;
		half();
		scl_out = 1'b0;
		half();
	endtask
	task automatic stop();
		sda_low_out = 1'b1;
		half();
		scl_out = 1'b1;
		half();
		sda_low_out = 1'b0;
		half();
	endtask
	// A one releases the line so the pull-up makes it.
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			sda_low_out = ~d[i];
			half();
			scl_out = 1'b1;
			half();
			q[i] = sda_in;
			scl_out = 1'b0;
		end
		sda_low_out = 1'b0;
	endtask
endmodule
`default_nettype wire

// File: ihc_host_port.sv
// Two-wire host control port: slave engine, attention output and outgoing byte queue.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Only all-zero address answered; write byte 0x00.
// - Device pulls data low on ninth clock.
// - Write bytes shifted in MSB first, acknowledged; here nacked while RX_READY_IN is low.
// - Attention low when outgoing data is pending.
// - Device acknowledges read address when ready.
// - Read bits change on falling clock edges.
// - Attention stays low until last bit rise.
// - Attention stays high until ack-bit rise.
// - Same write procedure for any transfer length.
// - Data line open-drain; ones by releasing driver.
module ihc_host_port
	import ihc_pkg::*;
#(
	parameter int DATA_W = IHC_DATA_W,
	parameter int FIFO_DEPTH = IHC_FIFO_DEPTH
) (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic CTRL_SERIAL_CLK_IN,
	input wire logic CTRL_DATA_IO_IN,
	output logic CTRL_DATA_IO_OUT,
	output logic CTRL_DATA_IO_OE_OUT,
	output logic HOST_ATTENTION_N_OUT,
	input wire logic [DATA_W-1:0] TX_DATA_IN,
	input wire logic TX_VALID_IN,
	output logic TX_READY_OUT,
	output logic [DATA_W-1:0] RX_DATA_OUT,
	output logic RX_VALID_OUT,
	input wire logic RX_READY_IN,
	output logic BUSY_OUT
);
	logic scl_s1_ff;
	logic scl_s2_ff;
	logic scl_prev_ff;
	logic sda_s1_ff;
	logic sda_s2_ff;
	logic sda_prev_ff;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	ihc_state_t state_ff;
	ihc_state_t nxt_state;
	logic [3:0] cnt_ff;
	logic [3:0] nxt_cnt;
	logic [7:0] rx_shift_ff;
	logic [7:0] nxt_rx_shift;
	logic [7:0] tx_shift_ff;
	logic [7:0] nxt_tx_shift;
	logic drive_ff;
	logic nxt_drive;
	logic rd_ff;
	logic nxt_rd;
	logic host_ack_ff;
	logic nxt_host_ack;
	logic att_n_ff;
	logic [DATA_W-1:0] rx_data_ff;
	logic rx_valid_ff;
	logic pop;
	logic push;

	logic [DATA_W-1:0] fifo_data;
	logic fifo_valid;

	ihc_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.in_data_in(TX_DATA_IN),
		.in_valid_in(TX_VALID_IN),
		.in_ready_out(TX_READY_OUT),
		.out_data_out(fifo_data),
		.out_valid_out(fifo_valid),
		.out_ready_in(pop)
	);

	// Both pins come from the host's timing; two stages each before any logic looks.
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			scl_s1_ff <= 1'b1;
			scl_s2_ff <= 1'b1;
			scl_prev_ff <= 1'b1;
		end else begin
			scl_s1_ff <= CTRL_SERIAL_CLK_IN;
			scl_s2_ff <= scl_s1_ff;
			scl_prev_ff <= scl_s2_ff;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			sda_s1_ff <= 1'b1;
			sda_s2_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end else begin
			sda_s1_ff <= CTRL_DATA_IO_IN;
			sda_s2_ff <= sda_s1_ff;
			sda_prev_ff <= sda_s2_ff;
		end
	end

	assign scl_rise = scl_s2_ff & ~scl_prev_ff;
	assign scl_fall = ~scl_s2_ff & scl_prev_ff;
	// Data moving while the clock stays high frames a transfer.
	assign start_seen = scl_s2_ff & scl_prev_ff & sda_prev_ff & ~sda_s2_ff;
	assign stop_seen = scl_s2_ff & scl_prev_ff & ~sda_prev_ff & sda_s2_ff;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_rx_shift = rx_shift_ff;
		nxt_tx_shift = tx_shift_ff;
		nxt_drive = drive_ff;
		nxt_rd = rd_ff;
		nxt_host_ack = host_ack_ff;
		pop = 1'b0;
		push = 1'b0;
		if (stop_seen) begin
			nxt_state = IHC_IDLE;
			nxt_drive = 1'b0;
		end else if (start_seen) begin
			// A repeated start also lands here, so a restarted read is always clean.
			nxt_state = IHC_ADDR;
			nxt_cnt = 4'h0;
			nxt_drive = 1'b0;
		end else begin
			unique case (state_ff)
				IHC_IDLE: begin
					nxt_drive = 1'b0;
				end
				IHC_ADDR: begin
					if (scl_rise) begin
						nxt_rx_shift = {rx_shift_ff[6:0], sda_s2_ff};
						nxt_cnt = cnt_ff + 4'h1;
					end
					if (scl_fall && cnt_ff == IHC_BITS_PER_BYTE) begin
						nxt_rd = rx_shift_ff[0];
						// A read is only acknowledged when a byte is waiting.
						if (rx_shift_ff[7:1] == IHC_DEV_ADDR && (!rx_shift_ff[0] || fifo_valid)) begin
							nxt_state = IHC_ADDR_ACK;
							nxt_drive = 1'b1;
						end else begin
							nxt_state = IHC_IDLE;
							nxt_drive = 1'b0;
						end
					end
				end
				IHC_ADDR_ACK: begin
					if (scl_fall) begin
						nxt_cnt = 4'h0;
						if (rd_ff) begin
							nxt_state = IHC_RD_BYTE;
							nxt_tx_shift = fifo_valid ? fifo_data : IHC_NULL_BYTE;
							pop = fifo_valid;
							nxt_drive = ~nxt_tx_shift[7];
						end else begin
							nxt_state = IHC_WR_BYTE;
							nxt_drive = 1'b0;
						end
					end
				end
				IHC_WR_BYTE: begin
					if (scl_rise) begin
						nxt_rx_shift = {rx_shift_ff[6:0], sda_s2_ff};
						nxt_cnt = cnt_ff + 4'h1;
					end
					if (scl_fall && cnt_ff == IHC_BITS_PER_BYTE) begin
						nxt_state = IHC_WR_ACK;
						// Refusing a byte the user cannot take makes the host resend it.
						nxt_drive = RX_READY_IN;
						push = RX_READY_IN;
					end
				end
				IHC_WR_ACK: begin
					// Bytes keep coming until the stop, however long the stream.
					if (scl_fall) begin
						nxt_state = IHC_WR_BYTE;
						nxt_cnt = 4'h0;
						nxt_drive = 1'b0;
					end
				end
				IHC_RD_BYTE: begin
					if (scl_rise) begin
						nxt_cnt = cnt_ff + 4'h1;
					end
					if (scl_fall) begin
						if (cnt_ff == IHC_BITS_PER_BYTE) begin
							nxt_state = IHC_RD_ACK;
							nxt_drive = 1'b0;
						end else begin
							nxt_tx_shift = {tx_shift_ff[6:0], 1'b0};
							nxt_drive = ~tx_shift_ff[6];
						end
					end
				end
				IHC_RD_ACK: begin
					if (scl_rise) begin
						nxt_host_ack = ~sda_s2_ff;
					end
					if (scl_fall) begin
						nxt_cnt = 4'h0;
						// An ack with nothing queued shifts out a null byte.
						if (host_ack_ff) begin
							nxt_state = IHC_RD_BYTE;
							nxt_tx_shift = fifo_valid ? fifo_data : IHC_NULL_BYTE;
							pop = fifo_valid;
							nxt_drive = ~nxt_tx_shift[7];
						end else begin
							nxt_state = IHC_IDLE;
							nxt_drive = 1'b0;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			state_ff <= IHC_IDLE;
			cnt_ff <= 4'h0;
			rd_ff <= 1'b0;
			host_ack_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			rd_ff <= nxt_rd;
			host_ack_ff <= nxt_host_ack;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			rx_shift_ff <= 8'h00;
			tx_shift_ff <= 8'h00;
		end else begin
			rx_shift_ff <= nxt_rx_shift;
			tx_shift_ff <= nxt_tx_shift;
		end
	end

	// The pad only ever pulls low; a one is the released line.
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			drive_ff <= 1'b0;
		end else begin
			drive_ff <= nxt_drive;
		end
	end

	// The attention level only moves at the two edges the host watches while reading,
	// so a host that samples after each byte never sees a glitch mid-byte.
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			att_n_ff <= IHC_ATT_RESET;
		end else if (state_ff == IHC_RD_BYTE) begin
			if (scl_rise && cnt_ff == IHC_LAST_BIT_RISE) begin
				att_n_ff <= ~fifo_valid;
			end
		end else if (state_ff == IHC_RD_ACK) begin
			if (scl_rise) begin
				att_n_ff <= ~fifo_valid;
			end
		end else begin
			att_n_ff <= ~fifo_valid;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			rx_data_ff <= '0;
			rx_valid_ff <= 1'b0;
		end else begin
			rx_valid_ff <= push;
			if (push) begin
				rx_data_ff <= rx_shift_ff;
			end
		end
	end

	assign CTRL_DATA_IO_OUT = 1'b0;
	assign CTRL_DATA_IO_OE_OUT = drive_ff;
	assign HOST_ATTENTION_N_OUT = att_n_ff;
	assign RX_DATA_OUT = rx_data_ff;
	assign RX_VALID_OUT = rx_valid_ff;
	assign BUSY_OUT = (state_ff != IHC_IDLE);

endmodule
`default_nettype wire

// File: ihc_host_port_bench.sv
// Self-checking bench for the host port against queue models of both streams.
`timescale 1ns/100ps
`default_nettype none
module ihc_host_port_bench;
	import ihc_pkg::*;
	logic clk = 1'b0;
	logic lclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic tx_valid = 1'b0;
	logic rx_ready = 1'b1;
	logic scl, host_low, oe, att, tx_ready, rx_valid, busy;
	logic [7:0] rx_data;
	wire logic sda = ~(host_low | oe);
	logic [31:0] seed = 32'haf0c3493;
	logic [8:0] q;
	logic [7:0] txq[$];
	logic [7:0] rxq[$];
	int n_fail = 0;
	int checks_done = 0;
	int cycles = 0;
	always #2 clk = ~clk;
	initial #5 forever #16 lclk = ~lclk;
	ihc_host_port DUT (.CLK_IN(clk), .RST_N_IN(rst_n), .CTRL_SERIAL_CLK_IN(scl),
		.CTRL_DATA_IO_IN(sda), .CTRL_DATA_IO_OUT(), .CTRL_DATA_IO_OE_OUT(oe),
		.HOST_ATTENTION_N_OUT(att), .TX_DATA_IN(tx_data), .TX_VALID_IN(tx_valid),
		.TX_READY_OUT(tx_ready), .RX_DATA_OUT(rx_data), .RX_VALID_OUT(rx_valid),
		.RX_READY_IN(rx_ready), .BUSY_OUT(busy));
	ihc_host_model hm (.lclk_in(lclk), .sda_in(sda), .scl_out(scl), .sda_low_out(host_low));
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic wr(input logic [7:0] d, input logic nak);
		hm.xfer({d, 1'b1}, q);
		chk("ack", q[0], nak);
	endtask
	task end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (rx_valid === 1'b1) rxq.push_back(rx_data);
		if (cycles == 60000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		#1 rst_n = 1'b1;
		@(posedge clk);
		#1 chk("att", att, 1'b1);
		hm.start();
		chk("busy", busy, 1'b1);
		wr({IHC_DEV_ADDR, 1'b0}, 1'b0);
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			wr(seed[7:0], 1'b0);
			chk("rx", rxq.pop_front(), seed[7:0]);
		end
		hm.stop();
		chk("busy", busy, 1'b0);
		hm.start();
		wr(8'h42, 1'b1);
		hm.stop();
		hm.start();
		wr(8'h00, 1'b0);
		@(posedge clk);
		#1 rx_ready = 1'b0;
		wr(8'h5a, 1'b1);
		@(posedge clk);
		#1 rx_ready = 1'b1;
		wr(8'h5a, 1'b0);
		hm.stop();
		chk("rx", rxq.pop_front(), 8'h5a);
		chk("rxn", rxq.size(), 0);
		hm.start();
		wr(8'h01, 1'b1);
		hm.stop();
		@(posedge clk);
		#1 tx_valid = 1'b1;
		for (int i = 0; i < 40; i++) begin
			seed = lfsr(seed);
			tx_data = seed[7:0];
			if (tx_ready === 1'b1) txq.push_back(tx_data);
			@(posedge clk);
			#1;
		end
		tx_valid = 1'b0;
		chk("fill", txq.size(), IHC_FIFO_DEPTH);
		chk("att", att, 1'b0);
		hm.start();
		wr(8'h01, 1'b0);
		while (txq.size() > 0) begin
			hm.xfer({8'hff, txq.size() == 1}, q);
			chk("rd", q[8:1], txq.pop_front());
			chk("att", att, txq.size() == 0);
		end
		hm.stop();
		chk("busy", busy, 1'b0);
		@(posedge clk);
		#1 tx_valid = 1'b1;
		seed = lfsr(seed);
		tx_data = seed[7:0];
		txq.push_back(tx_data);
		@(posedge clk);
		#1 tx_valid = 1'b0;
		hm.start();
		wr(8'h01, 1'b0);
		// A byte queued after the last-bit rise pulls attention low again at the ack rise.
		fork
			hm.xfer(9'h1ff, q);
			begin
				@(posedge att);
				@(posedge clk);
				#1 tx_valid = 1'b1;
				tx_data = ~txq[0];
				txq.push_back(tx_data);
				@(posedge clk);
				#1 tx_valid = 1'b0;
			end
		join
		chk("rd", q[8:1], txq.pop_front());
		chk("att", att, 1'b0);
		hm.stop();
		hm.start();
		wr(8'h01, 1'b0);
		hm.xfer(9'h1fe, q);
		chk("rd", q[8:1], txq.pop_front());
		hm.xfer(9'h1ff, q);
		chk("null", q[8:1], IHC_NULL_BYTE);
		chk("att", att, 1'b1);
		hm.stop();
		chk("busy", busy, 1'b0);
		end_of_test();
	end
endmodule
`default_nettype wire

// File: ihc_host_port_props.sv
// Concurrent checks on the host port pins and byte handshakes.
`timescale 1ns/100ps
`default_nettype none
module ihc_host_port_props (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic CTRL_SERIAL_CLK_IN,
	input wire logic CTRL_DATA_IO_IN,
	input wire logic CTRL_DATA_IO_OUT,
	input wire logic CTRL_DATA_IO_OE_OUT,
	input wire logic HOST_ATTENTION_N_OUT,
	input wire logic TX_VALID_IN,
	input wire logic TX_READY_OUT,
	input wire logic RX_VALID_OUT,
	input wire logic BUSY_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	a_open_drain: assert property (CTRL_DATA_IO_OUT == 1'b0)
		else $error("data pin driven high");
	a_rx_pulse: assert property (RX_VALID_OUT |=> !RX_VALID_OUT)
		else $error("rx valid too long");
	a_rx_acked: assert property ($rose(RX_VALID_OUT) |-> CTRL_DATA_IO_OE_OUT)
		else $error("byte taken without ack");
	a_att_push: assert property (TX_VALID_IN && TX_READY_OUT && !BUSY_OUT
		|-> ##[1:3] !HOST_ATTENTION_N_OUT) else $error("attention not raised");
	a_att_rise_high: assert property ($rose(HOST_ATTENTION_N_OUT)
		|-> CTRL_SERIAL_CLK_IN) else $error("attention rose off a rise");
	// Slow bus half periods leave the device edges well inside the low phase.
	a_oe_scl_low: assert property ($changed(CTRL_DATA_IO_OE_OUT)
		|-> !CTRL_SERIAL_CLK_IN) else $error("data changed with clock high");
	a_start_busy: assert property ($fell(CTRL_DATA_IO_IN) && CTRL_SERIAL_CLK_IN
		|-> ##[1:8] BUSY_OUT) else $error("start missed");
	a_stop_idle: assert property ($rose(CTRL_DATA_IO_IN) && CTRL_SERIAL_CLK_IN
		|-> ##[1:8] !BUSY_OUT) else $error("stop missed");
	cover property ($rose(RX_VALID_OUT));
	cover property ($rose(HOST_ATTENTION_N_OUT));
	cover property ($fell(BUSY_OUT));
endmodule
bind ihc_host_port ihc_host_port_props u_props (
	.CLK_IN(CLK_IN),
	.RST_N_IN(RST_N_IN),
	.CTRL_SERIAL_CLK_IN(CTRL_SERIAL_CLK_IN),
	.CTRL_DATA_IO_IN(CTRL_DATA_IO_IN),
	.CTRL_DATA_IO_OUT(CTRL_DATA_IO_OUT),
	.CTRL_DATA_IO_OE_OUT(CTRL_DATA_IO_OE_OUT),
	.HOST_ATTENTION_N_OUT(HOST_ATTENTION_N_OUT),
	.TX_VALID_IN(TX_VALID_IN),
	.TX_READY_OUT(TX_READY_OUT),
	.RX_VALID_OUT(RX_VALID_OUT),
	.BUSY_OUT(BUSY_OUT)
);
`default_nettype wire

// File: ihc_pkg.sv
// Shared constants for the two-wire host control port.
package ihc_pkg;

	localparam int IHC_DATA_W = 8;
	localparam int IHC_FIFO_DEPTH = 32;
	localparam logic [6:0] IHC_DEV_ADDR = 7'h00;
	localparam logic [3:0] IHC_BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] IHC_LAST_BIT_RISE = 4'h7;
	localparam logic [7:0] IHC_NULL_BYTE = 8'h00;
	localparam logic IHC_ATT_RESET = 1'b1;

	typedef enum logic [2:0] {
		IHC_IDLE,
		IHC_ADDR,
		IHC_ADDR_ACK,
		IHC_WR_BYTE,
		IHC_WR_ACK,
		IHC_RD_BYTE,
		IHC_RD_ACK
	} ihc_state_t;

endpackage
